// [csfb_host.sv]
// ****
// Host side: classic single-cycle bus master
// ****
module csfb_host
(
  // Clock
  input  wire logic        clk_sys,
  // Master outputs
  output logic             wb_cyc,
  output logic             wb_stb,
  output logic             wb_we,
  output logic [9:0]       wb_adr,
  output logic [3:0]       wb_sel,
  output logic [31:0]      wb_wdat,
  // Slave answer
  input  wire logic [31:0] wb_rdat,
  input  wire logic        wb_ack
);
  // Idle bus from time zero
  initial
  begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 10'h000;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
  end

  // One transfer; request held until ack is sampled, bounded so a dead slave cannot hang us
  task automatic xfer(input logic we, input logic [9:0] adr, input logic [7:0] wd,
                      output logic [31:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    n = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_wdat <= {24'h0, wd}; // Only zero goes to reserved places
    while (!ok && n < 20)
    begin
      @(posedge clk_sys);
      n++;
      if (wb_ack === 1'b1)
      begin
        ok = 1'b1;
        rd = wb_rdat;
      end
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

// [csfb_pkg.sv]
// Behaviour
// - adc_flags bit 7 reads 1 only while the left ADC gain stage has reached its programmed gain.
// - adc_flags bit 3 reads 1 only while the right ADC gain stage has reached its programmed gain.
// - adc_flags bit 6 shows left ADC power and bit 2 right ADC power, 1 meaning powered up.
// - adc_flags bit 5 latches when left AGC gain hits its maximum and clears when read.
// - adc_flags bit 1 latches when right AGC gain hits its maximum and clears when read.
// - dac_power_flags bits 7, 6 and 5 show left DAC, line and headphone driver power.
// - dac_power_flags bits 3, 2 and 1 show right DAC, line and headphone driver power.
// - dac_gain_flags bit 4 (left) and bit 0 (right) read 1 while DAC gain equals its target.
// - overflow_latched_flags bits 7 and 6 latch DAC overflow since the last read, cleared by reading.
// - overflow_latched_flags bits 3 and 2 latch ADC overflow since the last read, cleared by reading.
// - overflow_live_flags bits 7 and 6 show present DAC overflow, never latched or cleared.
// - overflow_live_flags bits 3 and 2 show present ADC overflow, never latched.
// - Reserved registers and bits read zero and software writes only zero to them.
package csfb_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] RSVD_A_IDX     = 8'h23;
  localparam logic [7:0] ADC_FLAGS_IDX  = 8'h24;
  localparam logic [7:0] DAC_PWR_IDX    = 8'h25;
  localparam logic [7:0] DAC_GAIN_IDX   = 8'h26;
  localparam logic [7:0] RSVD_B_FIRST   = 8'h27;
  localparam logic [7:0] RSVD_B_LAST    = 8'h29;
  localparam logic [7:0] OVF_LATCH_IDX  = 8'h2a;
  localparam logic [7:0] OVF_LIVE_IDX   = 8'h2b;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h30;
  localparam logic [7:0] IRQ_MASK_IDX   = 8'h31;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int ADC_L_PGA_BIT = 7;
  localparam int ADC_L_PWR_BIT = 6;
  localparam int ADC_L_AGC_BIT = 5;
  localparam int ADC_R_PGA_BIT = 3;
  localparam int ADC_R_PWR_BIT = 2;
  localparam int ADC_R_AGC_BIT = 1;
  localparam int DAC_L_PWR_BIT = 7;
  localparam int L_LINE_BIT    = 6;
  localparam int L_HP_BIT      = 5;
  localparam int DAC_R_PWR_BIT = 3;
  localparam int R_LINE_BIT    = 2;
  localparam int R_HP_BIT      = 1;
  localparam int DAC_L_PGA_BIT = 4;
  localparam int DAC_R_PGA_BIT = 0;
  localparam int OVF_DAC_L_BIT = 7;
  localparam int OVF_DAC_R_BIT = 6;
  localparam int OVF_ADC_L_BIT = 3;
  localparam int OVF_ADC_R_BIT = 2;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] IRQ_VALID  = 8'hee;
  localparam int         ACK_CYCLES = 1;

endpackage

// [csfb_top.sv]
module csfb_top
  import csfb_pkg::*;
#(
  parameter int ADR_W = 10
)
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // ADC status from the codec core
  input  wire logic             left_adc_pga_settled,
  input  wire logic             right_adc_pga_settled,
  input  wire logic             left_adc_powered,
  input  wire logic             right_adc_powered,
  input  wire logic             left_agc_saturated,
  input  wire logic             right_agc_saturated,
  // DAC and driver status
  input  wire logic             left_dac_powered,
  input  wire logic             right_dac_powered,
  input  wire logic             left_line_driver_powered,
  input  wire logic             right_line_driver_powered,
  input  wire logic             left_headphone_driver_powered,
  input  wire logic             right_headphone_driver_powered,
  input  wire logic             left_dac_pga_settled,
  input  wire logic             right_dac_pga_settled,
  // Converter overflow, live levels
  input  wire logic             left_dac_overflow,
  input  wire logic             right_dac_overflow,
  input  wire logic             left_adc_overflow,
  input  wire logic             right_adc_overflow,
  // Interrupt
  output logic                  irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
    logic [7:0] adc_sticky;
    logic [7:0] ovf_sticky;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic       irq;
  } csfb_state_t;

  csfb_state_t s;
  csfb_state_t next_s;

  // Address match on the word index; byte offset bits are ignored
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
    hit = (adr[ADR_W-1:2] == (ADR_W-2)'(idx));
  endfunction

  logic       req;
  logic       rd;
  logic       wr;
  logic       rd_adc;
  logic       rd_ovf;
  logic       rd_rsvd;
  logic [7:0] adc_img;
  logic [7:0] dpwr_img;
  logic [7:0] dgain_img;
  logic [7:0] live_img;
  logic [7:0] adc_set;
  logic [7:0] ovf_set;
  logic [7:0] events;
  logic [7:0] w1c;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Ack is dropped for one cycle after each answer, so a request still held
  // after its ack is taken again, once every two cycles.
  assign req     = wb_cyc_i & wb_stb_i & ~s.ack;
  assign rd      = req & ~wb_we_i;
  assign wr      = req & wb_we_i & wb_sel_i[0];
  assign rd_adc  = rd & hit(wb_adr_i, ADC_FLAGS_IDX);
  assign rd_ovf  = rd & hit(wb_adr_i, OVF_LATCH_IDX);
  assign rd_rsvd = rd & (hit(wb_adr_i, RSVD_A_IDX)
                 | (wb_adr_i[ADR_W-1:2] >= (ADR_W-2)'(RSVD_B_FIRST)
                 &  wb_adr_i[ADR_W-1:2] <= (ADR_W-2)'(RSVD_B_LAST)));

  // ****************************************************************
  // Register images
  // ****************************************************************
  // Every image starts at zero so reserved bits read zero
  always_comb
  begin
    adc_img   = FLAG_RESET;
    dpwr_img  = FLAG_RESET;
    dgain_img = FLAG_RESET;
    live_img  = FLAG_RESET;
    adc_set   = FLAG_RESET;
    ovf_set   = FLAG_RESET;
    adc_img[ADC_L_PGA_BIT]  = left_adc_pga_settled;
    adc_img[ADC_R_PGA_BIT]  = right_adc_pga_settled;
    adc_img[ADC_L_PWR_BIT]  = left_adc_powered;
    adc_img[ADC_R_PWR_BIT]  = right_adc_powered;
    adc_img[ADC_L_AGC_BIT]  = s.adc_sticky[ADC_L_AGC_BIT];
    adc_img[ADC_R_AGC_BIT]  = s.adc_sticky[ADC_R_AGC_BIT];
    dpwr_img[DAC_L_PWR_BIT] = left_dac_powered;
    dpwr_img[L_LINE_BIT]    = left_line_driver_powered;
    dpwr_img[L_HP_BIT]      = left_headphone_driver_powered;
    dpwr_img[DAC_R_PWR_BIT] = right_dac_powered;
    dpwr_img[R_LINE_BIT]    = right_line_driver_powered;
    dpwr_img[R_HP_BIT]      = right_headphone_driver_powered;
    dgain_img[DAC_L_PGA_BIT] = left_dac_pga_settled;
    dgain_img[DAC_R_PGA_BIT] = right_dac_pga_settled;
    live_img[OVF_DAC_L_BIT] = left_dac_overflow;
    live_img[OVF_DAC_R_BIT] = right_dac_overflow;
    live_img[OVF_ADC_L_BIT] = left_adc_overflow;
    live_img[OVF_ADC_R_BIT] = right_adc_overflow;
    adc_set[ADC_L_AGC_BIT]  = left_agc_saturated;
    adc_set[ADC_R_AGC_BIT]  = right_agc_saturated;
    ovf_set[OVF_DAC_L_BIT]  = left_dac_overflow;
    ovf_set[OVF_DAC_R_BIT]  = right_dac_overflow;
    ovf_set[OVF_ADC_L_BIT]  = left_adc_overflow;
    ovf_set[OVF_ADC_R_BIT]  = right_adc_overflow;
  end

  // Interrupt events share bit positions with the flag registers
  assign events = adc_set | ovf_set;
  assign w1c    = (wr && hit(wb_adr_i, IRQ_STATUS_IDX)) ? wb_dat_i[7:0] : 8'h00;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_s     = s;
    next_s.ack = req;
    // Read data is captured at the edge that raises ack
    if (rd)
    begin
      if (hit(wb_adr_i, ADC_FLAGS_IDX))
        next_s.rdata = adc_img;
      else if (hit(wb_adr_i, DAC_PWR_IDX))
        next_s.rdata = dpwr_img;
      else if (hit(wb_adr_i, DAC_GAIN_IDX))
        next_s.rdata = dgain_img;
      else if (hit(wb_adr_i, OVF_LATCH_IDX))
        next_s.rdata = s.ovf_sticky;
      else if (hit(wb_adr_i, OVF_LIVE_IDX))
        next_s.rdata = live_img;
      else if (hit(wb_adr_i, IRQ_STATUS_IDX))
        next_s.rdata = s.irq_status;
      else if (hit(wb_adr_i, IRQ_MASK_IDX))
        next_s.rdata = s.irq_mask;
      else
        next_s.rdata = 8'h00;
    end
    // A set in the clearing cycle wins, so no event is lost
    next_s.adc_sticky = adc_set | (rd_adc ? 8'h00 : s.adc_sticky);
    next_s.ovf_sticky = ovf_set | (rd_ovf ? 8'h00 : s.ovf_sticky);
    next_s.irq_status = events | (s.irq_status & ~w1c);
    // Flag registers ignore writes; the mask is written here and interrupt status bits clear on a written one
    if (wr && hit(wb_adr_i, IRQ_MASK_IDX))
      next_s.irq_mask = wb_dat_i[7:0] & IRQ_VALID;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Everything clears to zero at reset
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  // Outputs come straight from the state flops
  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.rdata};
  assign irq      = s.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  chk_adc_left_pga: assert property ($past(rd_adc) |->
    wb_ack_o && wb_dat_o[ADC_L_PGA_BIT] == $past(left_adc_pga_settled))
    else $error("left adc gain flag wrong");
  chk_adc_right_pga: assert property ($past(rd_adc) |->
    wb_dat_o[ADC_R_PGA_BIT] == $past(right_adc_pga_settled))
    else $error("right adc gain flag wrong");
  chk_adc_power: assert property ($past(rd_adc) |->
    wb_dat_o[ADC_L_PWR_BIT] == $past(left_adc_powered)
    && wb_dat_o[ADC_R_PWR_BIT] == $past(right_adc_powered))
    else $error("adc power flag wrong");
  chk_agc_left_sticky: assert property (left_agc_saturated ##1 !rd_adc |=>
    s.adc_sticky[ADC_L_AGC_BIT])
    else $error("left agc flag not held");
  chk_agc_right_clear: assert property (rd_adc && !right_agc_saturated |=>
    !s.adc_sticky[ADC_R_AGC_BIT])
    else $error("right agc flag not cleared");
  chk_dac_left_power: assert property ($past(rd & hit(wb_adr_i, DAC_PWR_IDX)) |->
    wb_dat_o[7:5] == $past({left_dac_powered, left_line_driver_powered,
    left_headphone_driver_powered}))
    else $error("left dac power flags wrong");
  chk_dac_right_power: assert property ($past(rd & hit(wb_adr_i, DAC_PWR_IDX)) |->
    wb_dat_o[3:1] == $past({right_dac_powered, right_line_driver_powered,
    right_headphone_driver_powered}))
    else $error("right dac power flags wrong");
  chk_dac_gain: assert property ($past(rd & hit(wb_adr_i, DAC_GAIN_IDX)) |->
    wb_dat_o[7:0] == $past({3'h0, left_dac_pga_settled, 3'h0, right_dac_pga_settled}))
    else $error("dac gain flags wrong");
  chk_ovf_dac_sticky: assert property (left_dac_overflow ##1 rd_ovf ##1 1'b1 |->
    wb_dat_o[OVF_DAC_L_BIT])
    else $error("dac overflow not latched");
  chk_ovf_adc_clear: assert property (rd_ovf && !right_adc_overflow && !right_dac_overflow |=>
    !s.ovf_sticky[OVF_ADC_R_BIT] && !s.ovf_sticky[OVF_DAC_R_BIT])
    else $error("overflow flag not cleared");
  chk_live_dac: assert property ($past(rd & hit(wb_adr_i, OVF_LIVE_IDX)) |->
    wb_dat_o[7:6] == $past({left_dac_overflow, right_dac_overflow}))
    else $error("live dac overflow wrong");
  chk_live_adc: assert property ($past(rd & hit(wb_adr_i, OVF_LIVE_IDX)) |->
    wb_dat_o[3:2] == $past({left_adc_overflow, right_adc_overflow})
    && wb_dat_o[1:0] == 2'h0)
    else $error("live adc overflow wrong");
  chk_reserved_zero: assert property ($past(rd_rsvd) |-> wb_ack_o && wb_dat_o == 32'h0)
    else $error("reserved register not zero");
  chk_write_ignored: assert property (wr && !left_agc_saturated && !right_agc_saturated
    |=> s.adc_sticky == $past(s.adc_sticky))
    else $error("write changed a flag");
  chk_irq_level: assert property (irq == |(s.irq_status & s.irq_mask))
    else $error("interrupt level wrong");


  // ****************************************************************
  // Further checks
  // ****************************************************************
  // Read strobes per register, for the checks only
  logic rd_dpwr;
  logic rd_dgain;
  logic rd_live;

  assign rd_dpwr  = rd & hit(wb_adr_i, DAC_PWR_IDX);
  assign rd_dgain = rd & hit(wb_adr_i, DAC_GAIN_IDX);
  assign rd_live  = rd & hit(wb_adr_i, OVF_LIVE_IDX);

  // Handshake: one ack per taken request, never a stray one
  chk_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  chk_ack_after_req: assert property (req |=> wb_ack_o)
    else $error("request not answered");

  chk_ack_no_stray: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");

  // Read data: only the low byte carries a register
  chk_dat_upper_zero: assert property (wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");

  // Read data must not drift between reads; hosts may sample late
  chk_dat_holds: assert property (!$past(rd) |-> $stable(wb_dat_o))
    else $error("read data changed without read");

  // Reserved bit fields inside the mapped registers
  chk_adc_rsvd_bits: assert property ($past(rd_adc) |->
    wb_dat_o[4] == 1'b0 && wb_dat_o[0] == 1'b0)
    else $error("adc reserved bits not zero");

  chk_dpwr_rsvd_bits: assert property ($past(rd_dpwr) |->
    wb_dat_o[4] == 1'b0 && wb_dat_o[0] == 1'b0)
    else $error("dac power reserved bits not zero");

  chk_dgain_rsvd_bits: assert property ($past(rd_dgain) |->
    wb_dat_o[7:5] == 3'h0 && wb_dat_o[3:1] == 3'h0)
    else $error("dac gain reserved bits not zero");

  chk_ovf_rsvd_bits: assert property ($past(rd_ovf) |->
    wb_dat_o[5:4] == 2'h0 && wb_dat_o[1:0] == 2'h0)
    else $error("overflow reserved bits not zero");

  chk_live_rsvd_bits: assert property ($past(rd_live) |->
    wb_dat_o[5:4] == 2'h0)
    else $error("live reserved bits not zero");

  // Sticky bits never appear outside their own places
  chk_sticky_places: assert property ((s.adc_sticky & 8'hdd) == 8'h00
    && (s.ovf_sticky & 8'h33) == 8'h00)
    else $error("sticky bit in reserved place");

  // AGC saturation sets its bit on the next edge, read or not
  chk_agc_left_set: assert property (left_agc_saturated |=>
    s.adc_sticky[ADC_L_AGC_BIT])
    else $error("left agc flag not set");

  chk_agc_right_set: assert property (right_agc_saturated |=>
    s.adc_sticky[ADC_R_AGC_BIT])
    else $error("right agc flag not set");

  chk_agc_left_clear: assert property (rd_adc && !left_agc_saturated |=>
    !s.adc_sticky[ADC_L_AGC_BIT])
    else $error("left agc flag not cleared");

  chk_agc_right_hold: assert property (s.adc_sticky[ADC_R_AGC_BIT] && !rd_adc |=>
    s.adc_sticky[ADC_R_AGC_BIT])
    else $error("right agc flag not held");

  // A read returns the latched value before it is cleared
  chk_agc_read_value: assert property ($past(rd_adc) |->
    wb_dat_o[5] == $past(s.adc_sticky[5]) && wb_dat_o[1] == $past(s.adc_sticky[1]))
    else $error("agc flags read wrong");

  // Overflow latches set on the edge after the level
  chk_ovf_dac_set: assert property (left_dac_overflow || right_dac_overflow |=>
    (s.ovf_sticky[7:6] & $past({left_dac_overflow, right_dac_overflow}))
    == $past({left_dac_overflow, right_dac_overflow}))
    else $error("dac overflow flag not set");

  chk_ovf_adc_set: assert property (left_adc_overflow || right_adc_overflow |=>
    (s.ovf_sticky[3:2] & $past({left_adc_overflow, right_adc_overflow}))
    == $past({left_adc_overflow, right_adc_overflow}))
    else $error("adc overflow flag not set");

  chk_ovf_dac_clear: assert property (rd_ovf && !left_dac_overflow && !right_dac_overflow |=>
    s.ovf_sticky[7:6] == 2'h0)
    else $error("dac overflow flags not cleared");

  chk_ovf_adc_hold: assert property (s.ovf_sticky[OVF_ADC_L_BIT] && !rd_ovf |=>
    s.ovf_sticky[OVF_ADC_L_BIT])
    else $error("left adc overflow flag not held");

  chk_ovf_read_value: assert property ($past(rd_ovf) |->
    wb_dat_o[7:0] == $past(s.ovf_sticky))
    else $error("overflow latch read wrong");

  // Writes never touch the overflow latches
  chk_write_ovf_ignored: assert property (wr && !(|ovf_set) |=>
    s.ovf_sticky == $past(s.ovf_sticky))
    else $error("write changed an overflow flag");

  // Interrupt status catches every event level
  chk_irq_status_set: assert property (|events |=>
    (s.irq_status & $past(events)) == $past(events))
    else $error("interrupt event lost");

  chk_irq_mask_valid: assert property ((s.irq_mask & ~IRQ_VALID) == 8'h00)
    else $error("mask holds an invalid bit");

  // Main scenarios worth seeing at least once
  cov_agc_read: cover property (left_agc_saturated ##1 rd_adc ##1 wb_ack_o);
  cov_ovf_set_wins: cover property (rd_ovf && left_adc_overflow);
  cov_irq_rise: cover property (!irq ##1 irq);
  cov_reserved_read: cover property (rd_rsvd ##1 wb_ack_o);
  cov_irq_cleared: cover property (irq ##1 !irq);

endmodule

// [testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [17:0] st = 18'h0;
  logic cyc, stb, we, ack, irq;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  int fails = 0;
  int checked = 0;
  int i;
  // Rows: live inputs, byte address, expected low byte
  localparam logic [35:0] ROWS [13] = '{
    {18'h00009, 10'h090, 8'h84}, {18'h00006, 10'h090, 8'h48},
    {18'h00640, 10'h094, 8'ha4}, {18'h00980, 10'h094, 8'h4a},
    {18'h01000, 10'h098, 8'h10}, {18'h02000, 10'h098, 8'h01},
    {18'h24000, 10'h0ac, 8'h84}, {18'h18000, 10'h0ac, 8'h48},
    {18'h03fcf, 10'h090, 8'hcc}, {18'h03fcf, 10'h08c, 8'h00},
    {18'h03fcf, 10'h09c, 8'h00}, {18'h03fcf, 10'h0a4, 8'h00},
    {18'h03fcf, 10'h3fc, 8'h00}};
  // Sticky rows: one-cycle pulse, address, latched value
  localparam logic [35:0] SROWS [4] = '{
    {18'h00010, 10'h090, 8'h20}, {18'h00020, 10'h090, 8'h02},
    {18'h28000, 10'h0a8, 8'h44}, {18'h14000, 10'h0a8, 8'h88}};

  always #25 clk_sys = ~clk_sys;

  csfb_host csfb_host_i (.clk_sys(clk_sys), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
    .wb_adr(adr), .wb_sel(sel), .wb_wdat(wdat), .wb_rdat(rdat), .wb_ack(ack));

  csfb_top csfb_top_i (.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .left_adc_pga_settled(st[0]), .right_adc_pga_settled(st[1]),
    .left_adc_powered(st[2]), .right_adc_powered(st[3]), .left_agc_saturated(st[4]),
    .right_agc_saturated(st[5]), .left_dac_powered(st[6]), .right_dac_powered(st[7]),
    .left_line_driver_powered(st[8]), .right_line_driver_powered(st[9]),
    .left_headphone_driver_powered(st[10]), .right_headphone_driver_powered(st[11]),
    .left_dac_pga_settled(st[12]), .right_dac_pga_settled(st[13]),
    .left_dac_overflow(st[14]), .right_dac_overflow(st[15]),
    .left_adc_overflow(st[16]), .right_adc_overflow(st[17]), .irq(irq));

  // ****
  // Shared tasks
  // ****
  task automatic give_verdict();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // A lost ack ends the run at once
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    logic ok;
    csfb_host_i.xfer(w, a, d, rd, ok);
    if (!ok)
    begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  task automatic pulse(input logic [17:0] p);
    @(posedge clk_sys);
    st <= p;
    @(posedge clk_sys);
    st <= 18'h0;
    repeat (2) @(posedge clk_sys);
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rchk(10'h090, 8'h00);
    rchk(10'h0a8, 8'h00);
    chk({31'h0, irq}, 32'h0);
    for (i = 0; i < 13; i++)
    begin
      @(posedge clk_sys);
      st <= ROWS[i][35:18];
      rchk(ROWS[i][17:8], ROWS[i][7:0]);
    end
    // Live levels still high: writes must not disturb them
    bus(1'b1, 10'h090, 8'hee);
    rchk(10'h090, 8'hcc);
    st <= 18'h0;
    rchk(10'h0a8, 8'hcc);
    rchk(10'h0a8, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      pulse(SROWS[i][35:18]);
      rchk(SROWS[i][17:8], SROWS[i][7:0]);
      rchk(SROWS[i][17:8], 8'h00);
      rchk(10'h0ac, 8'h00);
    end
    // Interrupt: clear, unmask, raise, clear, then masked event
    bus(1'b1, 10'h0c0, 8'hff);
    bus(1'b1, 10'h0c4, 8'hff);
    rchk(10'h0c4, 8'hee);
    pulse(18'h04000);
    chk({31'h0, irq}, 32'h1);
    rchk(10'h0c0, 8'h80);
    bus(1'b1, 10'h0c0, 8'h80);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 10'h0c4, 8'h00);
    pulse(18'h00020);
    chk({31'h0, irq}, 32'h0);
    rchk(10'h0c0, 8'h02);
    // Mid-run reset: latches, mask and interrupt must all return to zero
    pulse(18'h3c030);
    bus(1'b1, 10'h0c4, 8'hff);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rchk(10'h090, 8'h00);
    rchk(10'h0a8, 8'h00);
    rchk(10'h0c4, 8'h00);
    chk({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule
